// File: hw/hub_port_config_registers.sv
`timescale 1ns/1ns
module hub_port_config_registers
  import hub_cfg_pkg::*;
#(
  parameter int PORTS = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input hub_cfg_pkg::cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic [5:0] product_rd_index,
  output logic [7:0] product_rd_byte,
  input wire logic [5:0] serial_rd_index,
  output logic [7:0] serial_rd_byte,
  output logic [7:0] product_text_count,
  output logic [7:0] serial_text_count,
  output hub_cfg_pkg::port_cfg_t port_cfg,
  input wire logic up_core_plus,
  input wire logic up_core_minus,
  output logic upstream_plus_pin,
  output logic upstream_minus_pin,
  input wire logic [4:1] dn_core_plus,
  input wire logic [4:1] dn_core_minus,
  output logic [4:1] downstream_plus_pins,
  output logic [4:1] downstream_minus_pins
);
  import hub_cfg_pkg::*;

  logic [7:0] charge_q;
  logic [7:0] up_gain_q;
  logic [7:0] dn_gain_q;
  logic [7:0] exchange_q;
  logic [7:0] product_count_q;
  logic [7:0] serial_count_q;
  logic [7:0] cfg_rdata_q;
  logic cfg_rvalid_q;
  logic product_hit;
  logic serial_hit;
  logic [5:0] product_off;
  logic [5:0] serial_off;
  logic [5:0] cfg_prod_idx;
  logic [5:0] cfg_ser_idx;
  logic [7:0] prod_cfg_byte;
  logic [7:0] ser_cfg_byte;
  logic [7:0] prod_port_byte;
  logic [7:0] ser_port_byte;
  logic charge_we;
  logic up_gain_we;
  logic dn_gain_we;
  logic exchange_we;
  logic product_count_we;
  logic serial_count_we;
  logic [7:0] cfg_rdata_d;

  // Address decode of the two text windows
  always_comb
  begin
    product_hit = (cfg_req.addr >= PRODUCT_TEXT_BASE) &&
                  (cfg_req.addr <= PRODUCT_TEXT_LAST); // [R1]
    serial_hit = (cfg_req.addr >= SERIAL_TEXT_BASE) &&
                 (cfg_req.addr <= SERIAL_TEXT_LAST); // [R2]
  end

  assign product_off = 6'(cfg_req.addr - PRODUCT_TEXT_BASE);
  assign serial_off = 6'(cfg_req.addr - SERIAL_TEXT_BASE);

  // Config reads share one port of each array with the descriptor reader
  assign cfg_prod_idx = (cfg_req.rd && product_hit) ? product_off : product_rd_index;
  assign cfg_ser_idx = (cfg_req.rd && serial_hit) ? serial_off : serial_rd_index;

  // Byte addresses map one to one, so low-then-high order is kept as written
  text_store #(.DEPTH(TEXT_BYTES), .AW(TEXT_ADDR_W)) product_store ( // [R3] [R4]
    .clock(clock),
    .wr_en(cfg_req.wr && product_hit),
    .wr_addr(product_off),
    .wr_data(cfg_req.wdata),
    .rd_addr(cfg_prod_idx),
    .rd_data(prod_cfg_byte)
  );

  text_store #(.DEPTH(TEXT_BYTES), .AW(TEXT_ADDR_W)) serial_store ( // [R3] [R4]
    .clock(clock),
    .wr_en(cfg_req.wr && serial_hit),
    .wr_addr(serial_off),
    .wr_data(cfg_req.wdata),
    .rd_addr(cfg_ser_idx),
    .rd_data(ser_cfg_byte)
  );

  assign prod_port_byte = prod_cfg_byte;
  assign ser_port_byte = ser_cfg_byte;

  // Write strobes, one per register, so each process below keeps one concern
  always_comb
  begin
    charge_we = cfg_req.wr && (cfg_req.addr == CHARGE_ADDR);
    up_gain_we = cfg_req.wr && (cfg_req.addr == UP_GAIN_ADDR);
    dn_gain_we = cfg_req.wr && (cfg_req.addr == DN_GAIN_ADDR);
    exchange_we = cfg_req.wr && (cfg_req.addr == EXCHANGE_ADDR);
    product_count_we = cfg_req.wr && (cfg_req.addr == PRODUCT_COUNT_ADDR);
    serial_count_we = cfg_req.wr && (cfg_req.addr == SERIAL_COUNT_ADDR);
  end

  // Product byte for the port logic; a config read of this area takes the index
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      product_rd_byte <= 8'h00;
    else
      product_rd_byte <= prod_port_byte;
  end

  // Serial byte for the port logic, shared the same way as the product byte
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      serial_rd_byte <= 8'h00;
    else
      serial_rd_byte <= ser_port_byte;
  end

  // Charge enables; bit 0 and bits 7:5 masked so they always read zero
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      charge_q <= CTRL_RESET;
    else if (charge_we)
      charge_q <= cfg_req.wdata & CHARGE_MASK; // [R5] [R12]
  end

  // Upstream gain code; only the low two bits are kept
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      up_gain_q <= CTRL_RESET;
    else if (up_gain_we)
      up_gain_q <= cfg_req.wdata & UP_GAIN_MASK; // [R6] [R12]
  end

  // Downstream gain codes, two bits per port, every bit in use
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      dn_gain_q <= CTRL_RESET;
    else if (dn_gain_we)
      dn_gain_q <= cfg_req.wdata & DN_GAIN_MASK; // [R7]
  end

  // Pair exchange bits; bits 7:5 masked
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      exchange_q <= CTRL_RESET;
    else if (exchange_we)
      exchange_q <= cfg_req.wdata & EXCHANGE_MASK; // [R9] [R10] [R12]
  end

  // Product length, stored raw so software reads back what it wrote
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      product_count_q <= COUNT_RESET;
    else if (product_count_we)
      product_count_q <= cfg_req.wdata; // [R11]
  end

  // Serial length, stored raw as well
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      serial_count_q <= COUNT_RESET;
    else if (serial_count_we)
      serial_count_q <= cfg_req.wdata; // [R11]
  end

  // Port logic sees at most 31 characters even if software wrote more
  assign product_text_count = (product_count_q > MAX_CHARS) ? MAX_CHARS : product_count_q; // [R11]
  assign serial_text_count = (serial_count_q > MAX_CHARS) ? MAX_CHARS : serial_count_q; // [R11]

  // Read data select; unmapped addresses read zero, idle cycles keep the last answer
  always_comb
  begin
    cfg_rdata_d = cfg_rdata_q;
    if (cfg_req.rd)
    begin
      if (product_hit)
        cfg_rdata_d = prod_cfg_byte; // [R1]
      else if (serial_hit)
        cfg_rdata_d = ser_cfg_byte; // [R2]
      else
      begin
        unique case (cfg_req.addr)
          CHARGE_ADDR: cfg_rdata_d = charge_q; // [R12]
          UP_GAIN_ADDR: cfg_rdata_d = up_gain_q;
          DN_GAIN_ADDR: cfg_rdata_d = dn_gain_q;
          EXCHANGE_ADDR: cfg_rdata_d = exchange_q;
          PRODUCT_COUNT_ADDR: cfg_rdata_d = product_count_q;
          SERIAL_COUNT_ADDR: cfg_rdata_d = serial_count_q;
          default: cfg_rdata_d = 8'h00;
        endcase
      end
    end
  end

  // Read data stands until the next read, so a slow source may sample it late
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      cfg_rdata_q <= 8'h00;
    else
      cfg_rdata_q <= cfg_rdata_d;
  end

  // Answer strobe, one cycle after each read
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      cfg_rvalid_q <= 1'b0;
    else
      cfg_rvalid_q <= cfg_req.rd;
  end

  assign cfg_rdata = cfg_rdata_q;
  assign cfg_rvalid = cfg_rvalid_q;

  // Settings fanned out to ports; gain code 00 is the compliant default
  always_comb
  begin
    port_cfg.charge_support_on = charge_q[4:1]; // [R5]
    port_cfg.upstream_gain_code = gain_code_t'(up_gain_q[1:0]); // [R6] [R8]
    port_cfg.port4_gain_code = gain_code_t'(dn_gain_q[7:6]); // [R7]
    port_cfg.port3_gain_code = gain_code_t'(dn_gain_q[5:4]);
    port_cfg.port2_gain_code = gain_code_t'(dn_gain_q[3:2]);
    port_cfg.port1_gain_code = gain_code_t'(dn_gain_q[1:0]);
    port_cfg.pair_exchange_bits = exchange_q[4:0];
  end

  // Upstream pair routing
  pair_route up_route (
    .exchange(exchange_q[0]), // [R10]
    .core_plus(up_core_plus),
    .core_minus(up_core_minus),
    .pin_plus(upstream_plus_pin),
    .pin_minus(upstream_minus_pin)
  );

  // Downstream pair routing, one per port
  for (genvar p = 1; p <= PORTS; p++)
  begin : g_dn
    pair_route dn_route (
      .exchange(exchange_q[p]), // [R9]
      .core_plus(dn_core_plus[p]),
      .core_minus(dn_core_minus[p]),
      .pin_plus(downstream_plus_pins[p]),
      .pin_minus(downstream_minus_pins[p])
    );
  end
endmodule

// File: hw/hub_cfg_pkg.sv
// What this block does
// [R1] Product text bytes live at addresses 0x54 to 0x91, eight bits each.
// [R2] Serial text bytes live at addresses 0x92 to 0xcf, eight bits each.
// [R3] Each text area holds up to 31 sixteen-bit characters, 62 bytes.
// [R4] Writer stores each character low byte first, characters at ascending addresses.
// [R5] Register 0xd0 bits 1 to 4 enable charging on ports 1 to 4.
// [R6] Register 0xf6 bits 1:0 hold the upstream gain code; 7:2 reserved.
// [R7] Register 0xf8 holds one two-bit gain code per downstream port.
// [R8] Software should keep gain codes at 00 unless the board needs more drive.
// [R9] Register 0xfa bits 1 to 4 exchange plus and minus pins of ports 1 to 4.
// [R10] Bit 0 of register 0xfa exchanges the upstream plus and minus pins.
// [R11] Valid character counts come from separate length registers, at most 31.
// [R12] Reserved bits ignore writes and read as zero.
package hub_cfg_pkg;
  localparam logic [7:0] PRODUCT_TEXT_BASE = 8'h54;
  localparam logic [7:0] PRODUCT_TEXT_LAST = 8'h91;
  localparam logic [7:0] SERIAL_TEXT_BASE = 8'h92;
  localparam logic [7:0] SERIAL_TEXT_LAST = 8'hcf;
  localparam logic [7:0] PRODUCT_COUNT_ADDR = 8'h14;
  localparam logic [7:0] SERIAL_COUNT_ADDR = 8'h15;
  localparam logic [7:0] CHARGE_ADDR = 8'hd0;
  localparam logic [7:0] UP_GAIN_ADDR = 8'hf6;
  localparam logic [7:0] DN_GAIN_ADDR = 8'hf8;
  localparam logic [7:0] EXCHANGE_ADDR = 8'hfa;
  localparam int TEXT_BYTES = 62;
  localparam int TEXT_ADDR_W = 6;
  localparam logic [7:0] MAX_CHARS = 8'h1f;
  localparam logic [7:0] CHARGE_MASK = 8'h1e;
  localparam logic [7:0] UP_GAIN_MASK = 8'h03;
  localparam logic [7:0] DN_GAIN_MASK = 8'hff;
  localparam logic [7:0] EXCHANGE_MASK = 8'h1f;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam int NUM_PORTS = 4;

  typedef enum logic [1:0] {GAIN_NONE, GAIN_LOW, GAIN_MEDIUM, GAIN_HIGH} gain_code_t;

  // Register access request from the configuration source
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfg_req_t;

  // Settings presented to the port logic
  typedef struct packed {
    logic [NUM_PORTS:1] charge_support_on;
    gain_code_t upstream_gain_code;
    gain_code_t port4_gain_code;
    gain_code_t port3_gain_code;
    gain_code_t port2_gain_code;
    gain_code_t port1_gain_code;
    logic [NUM_PORTS:0] pair_exchange_bits;
  } port_cfg_t;
endpackage

// File: hw/text_store.sv
`timescale 1ns/1ns
// Byte array for one descriptor text area
module text_store #(
  parameter int DEPTH = 62,
  parameter int AW = 6
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  // No reset on the array: contents are loaded before use
  always_ff @(posedge clock)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // Out of range reads return zero
  always_comb
  begin
    rd_data = 8'h00;
    if (int'(rd_addr) < DEPTH)
      rd_data = mem[rd_addr];
  end
endmodule

// File: hw/pair_route.sv
`timescale 1ns/1ns
// Exchanges the plus and minus lines of one differential pair
module pair_route (
  input wire logic exchange,
  input wire logic core_plus,
  input wire logic core_minus,
  output logic pin_plus,
  output logic pin_minus
);
  assign pin_plus = exchange ? core_minus : core_plus;
  assign pin_minus = exchange ? core_plus : core_minus;
endmodule

// File: testbench/hub_cfg_checker.sv
`timescale 1ns/1ns
// Ties register writes to the settings and pins that follow them
module hub_cfg_checker (
  input wire logic clock,
  input wire logic arst_n,
  input hub_cfg_pkg::cfg_req_t cfg_req,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic [7:0] product_text_count,
  input hub_cfg_pkg::port_cfg_t port_cfg,
  input wire logic up_core_plus,
  input wire logic up_core_minus,
  input wire logic upstream_plus_pin,
  input wire logic [4:1] dn_core_plus,
  input wire logic [4:1] dn_core_minus,
  input wire logic [4:1] downstream_plus_pins
);
  import hub_cfg_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_read_answer: assert property (cfg_req.rd |=> cfg_rvalid)
    else $error("read not answered next cycle");
  a_answer_cause: assert property (cfg_rvalid |-> $past(cfg_req.rd))
    else $error("read answer without a read");
  a_charge_write: assert property (cfg_req.wr && cfg_req.addr == CHARGE_ADDR
    |=> port_cfg.charge_support_on == $past(cfg_req.wdata[4:1])) else $error("charge bits wrong");
  a_up_gain: assert property (cfg_req.wr && cfg_req.addr == UP_GAIN_ADDR
    |=> port_cfg.upstream_gain_code == $past(cfg_req.wdata[1:0])) else $error("up gain wrong");
  a_dn_gain: assert property (cfg_req.wr && cfg_req.addr == DN_GAIN_ADDR
    |=> {port_cfg.port4_gain_code, port_cfg.port3_gain_code, port_cfg.port2_gain_code,
    port_cfg.port1_gain_code} == $past(cfg_req.wdata)) else $error("down gain wrong");
  a_swap_write: assert property (cfg_req.wr && cfg_req.addr == EXCHANGE_ADDR
    |=> port_cfg.pair_exchange_bits == $past(cfg_req.wdata[4:0])) else $error("swap bits wrong");
  a_up_route: assert property (upstream_plus_pin ==
    (port_cfg.pair_exchange_bits[0] ? up_core_minus : up_core_plus)) else $error("up route");
  a_dn_route: assert property (downstream_plus_pins ==
    ((dn_core_plus & ~port_cfg.pair_exchange_bits[4:1]) |
    (dn_core_minus & port_cfg.pair_exchange_bits[4:1]))) else $error("down route");
  a_reserved_zero: assert property (cfg_rvalid && $past(cfg_req.addr) == CHARGE_ADDR
    |-> cfg_rdata[7:5] == 3'h0 && !cfg_rdata[0]) else $error("reserved bits not zero");
  a_count_clamp: assert property (product_text_count <= MAX_CHARS)
    else $error("count above limit");
  cover property (cfg_req.wr && cfg_req.addr == EXCHANGE_ADDR);
  cover property (cfg_rvalid);
  cover property (port_cfg.port4_gain_code == GAIN_HIGH);
endmodule
bind hub_port_config_registers hub_cfg_checker u_hub_cfg_checker (.clock, .arst_n, .cfg_req,
  .cfg_rdata, .cfg_rvalid, .product_text_count, .port_cfg, .up_core_plus, .up_core_minus,
  .upstream_plus_pin, .dn_core_plus, .dn_core_minus, .downstream_plus_pins);

// File: testbench/cfg_source.sv
`timescale 1ns/1ns
// Configuration writer; one strobe per request, then an idle edge
module cfg_source (
  input wire logic clock,
  output hub_cfg_pkg::cfg_req_t cfg_req
);
  import hub_cfg_pkg::*;
  initial cfg_req = '0;
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    cfg_req <= {w, ~w, a, d};
    @(posedge clock);
    cfg_req <= '0;
  endtask
  // Low byte first, so the text reads back in host order
  task automatic put_char(input logic [7:0] base, input int n, input logic [15:0] c);
    put(1'b1, base + 8'(2 * n), c[7:0]);
    put(1'b1, base + 8'(2 * n + 1), c[15:8]);
  endtask
endmodule

// File: testbench/hub_port_config_registers_tb.sv
`timescale 1ns/1ns
module hub_port_config_registers_tb;
  import hub_cfg_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic clock, arst_n, up_core_plus, up_core_minus, cfg_rvalid;
  logic upstream_plus_pin, upstream_minus_pin;
  logic [5:0] product_rd_index, serial_rd_index;
  logic [4:1] dn_core_plus, dn_core_minus, downstream_plus_pins, downstream_minus_pins;
  logic [7:0] cfg_rdata, product_rd_byte, serial_rd_byte, product_text_count, serial_text_count;
  cfg_req_t cfg_req;
  port_cfg_t port_cfg;
  int n_errors = 0;
  int checks_done = 0;
  // Write value, expected readback; last row is unmapped
  row_t rows [10] = '{'{8'hd0, 8'hff, 8'h1e}, '{8'hd0, 8'h0b, 8'h0a}, '{8'hf6, 8'hff, 8'h03},
    '{8'hf6, 8'h01, 8'h01}, '{8'hf6, 8'h02, 8'h02}, '{8'hf8, 8'he4, 8'he4},
    '{8'hfa, 8'hff, 8'h1f}, '{8'hfa, 8'h15, 8'h15}, '{8'h14, 8'h40, 8'h40}, '{8'h10, 8'hab, 8'h00}};
  hub_port_config_registers u_hub_port_config_registers (.clock, .arst_n, .cfg_req, .cfg_rdata,
    .cfg_rvalid, .product_rd_index, .product_rd_byte, .serial_rd_index, .serial_rd_byte,
    .product_text_count, .serial_text_count, .port_cfg, .up_core_plus, .up_core_minus,
    .upstream_plus_pin, .upstream_minus_pin, .dn_core_plus, .dn_core_minus,
    .downstream_plus_pins, .downstream_minus_pins);
  cfg_source u_cfg_source (.clock, .cfg_req);
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_cfg_source.put(1'b1, a, d);
  endtask
  // Data is settled just after the edge that raises the answer
  task automatic rd(input logic [7:0] a);
    u_cfg_source.put(1'b0, a, 8'h00);
    #1;
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Cuts a hang short; the run needs under a hundred cycles
  initial
  begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    arst_n = 1'b0;
    up_core_plus = 1'b1;
    up_core_minus = 1'b0;
    dn_core_plus = 4'h5;
    dn_core_minus = 4'ha;
    product_rd_index = 6'h00;
    serial_rd_index = 6'h00;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    rd(CHARGE_ADDR);
    check("reset_charge", 8'h00, cfg_rdata);
    check("reset_count", 8'h00, product_text_count);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      check("readback", rows[i].e, cfg_rdata);
    end
    check("up_pins", 8'h01, {6'h00, upstream_plus_pin, upstream_minus_pin});
    check("dn_pins", 8'hf0, {downstream_plus_pins, downstream_minus_pins});
    check("count_clamp", MAX_CHARS, product_text_count);
    wr(SERIAL_COUNT_ADDR, 8'h20);
    #1;
    check("serial_clamp", MAX_CHARS, serial_text_count);
    // Last product character sits against the first serial one
    u_cfg_source.put_char(PRODUCT_TEXT_BASE, 30, 16'hbeef);
    u_cfg_source.put_char(SERIAL_TEXT_BASE, 0, 16'h1234);
    rd(PRODUCT_TEXT_LAST);
    check("product_last", 8'hbe, cfg_rdata);
    rd(SERIAL_TEXT_BASE);
    check("serial_first", 8'h34, cfg_rdata);
    @(posedge clock);
    product_rd_index <= 6'd60;
    serial_rd_index <= 6'd1;
    @(posedge clock);
    #1;
    check("product_port", 8'hef, product_rd_byte);
    check("serial_port", 8'h12, serial_rd_byte);
    // Writer puts the gains back to the compliant code before the pins are used
    wr(UP_GAIN_ADDR, 8'h00);
    wr(DN_GAIN_ADDR, 8'h00);
    rd(DN_GAIN_ADDR);
    check("gain_restore", 8'h00, cfg_rdata);
    // Reset in mid-run puts the upstream pair and all four downstream pairs back to normal routing
    @(posedge clock);
    arst_n <= 1'b0;
    @(posedge clock);
    #1;
    check("reset_up_pins", 8'h02, {6'h00, upstream_plus_pin, upstream_minus_pin});
    check("reset_dn_pins", 8'h5a, {downstream_plus_pins, downstream_minus_pins});
    check("reset_serial_count", 8'h00, serial_text_count);
    @(posedge clock);
    arst_n <= 1'b1;
    rd(CHARGE_ADDR);
    check("reset_readback", 8'h00, cfg_rdata);
    tally_and_finish();
  end
endmodule
